// ===== arr_pkg.sv
/*
 package of constants shared by both ends of the adjacent-row refresh link.
 assumes a 250 MHz command clock shared by controller and device.
*/
package arr_pkg;
    // ------------------------------------------------------------
    // command encoding on the link
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CMD_NOP = 3'h0,
        CMD_ACT = 3'h1,
        CMD_PRE = 3'h2,
        CMD_PRECHARGE_ALL_BANKS = 3'h3,
        CMD_MRW = 3'h4,
        CMD_REF = 3'h5,
        CMD_SRE = 3'h6
    } arr_cmd_e;
    // ------------------------------------------------------------
    // row_hammer_control fields
    // ------------------------------------------------------------
    localparam int OP_EN = 7;
    localparam int OP_BANK_HI = 6;
    localparam int OP_BANK_LO = 4;
    localparam int OP_UNLIM = 3;
    localparam int OP_MAC_HI = 2;
    localparam logic [2:0] MAC_UNLIMITED = 3'h0;
    // ------------------------------------------------------------
    // timing, ns and derived cycles at 4 ns
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int T_RAS_NS = 42;
    localparam int T_RP_NS = 18;
    localparam int T_MRD_NS = 14;
    localparam logic [7:0] C_RAS =
        8'((T_RAS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] C_RAS15 =
        8'((3 * T_RAS_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS));
    localparam logic [7:0] C_RP =
        8'((T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] C_MRD =
        8'((T_MRD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [1:0] PASSES = 2'h3;
    // ------------------------------------------------------------
    // controller register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [3:0] A_CTRL = 4'h0;
    localparam logic [3:0] A_ROW = 4'h4;
    localparam logic [3:0] A_STAT = 4'h8;
    localparam int CT_START = 0;
    localparam int CT_ABORT = 1;
    localparam int CT_BANK_LO = 4;
    localparam int CT_CALIB = 8;
    localparam int ST_BUSY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_REFUSED = 2;
    localparam int ST_MR_LO = 8;
endpackage : arr_pkg

// ===== arr_link_if.sv
/*
 command link between the memory controller and the device.
 assumes both ends clocked by the same command clock.
*/
`timescale 1ns/1ps
interface arr_link_if;
    arr_pkg::arr_cmd_e cmd;
    logic [2:0] ba;
    logic [13:0] row;
    logic [7:0] op;
    logic [7:0] rd_op;
    modport ctrl (output cmd, output ba, output row, output op,
        input rd_op);
    modport dev (input cmd, input ba, input row, input op,
        output rd_op);
endinterface : arr_link_if

// ===== arr_device.sv
/*
 device end: row_hammer_control register, precharge tracking,
 self-clear and victim restore. assumes a well-behaved controller.
*/
`timescale 1ns/1ps
module arr_device #(
    parameter logic [2:0] MAC_CODE = 3'h0,
    parameter logic UNLIM_FLAG = 1'b1
) (
    input wire logic CLK_I,
    input wire logic RST_B_I,
    arr_link_if.dev LINK,
    output logic MODE_ACTIVE_O,
    output logic UNLIMITED_O,
    output logic VICTIM_REFRESH_O,
    output logic [2:0] VICTIM_BANK_O,
    output logic [13:0] VICTIM_ROW_O,
    output logic [15:0] REFRESH_COUNT_O
);
    logic en, next_en;
    logic [2:0] bank, next_bank;
    logic [1:0] pre_cnt, next_pre_cnt;
    logic [7:0] timer, next_timer;
    logic clr_run, next_clr_run;
    logic [13:0] agg, next_agg;
    logic vic, next_vic;
    logic [15:0] ref_cnt, next_ref_cnt;
    logic unlim;
    logic hit_pre;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_en = en;
        next_bank = bank;
        next_pre_cnt = pre_cnt;
        next_timer = timer;
        next_clr_run = clr_run;
        next_agg = agg;
        next_vic = 1'b0;
        next_ref_cnt = ref_cnt;
        hit_pre = (LINK.cmd == arr_pkg::CMD_PRECHARGE_ALL_BANKS) ||
            (LINK.cmd == arr_pkg::CMD_PRE && LINK.ba == bank);
        unique case (LINK.cmd)
            arr_pkg::CMD_MRW: begin
                if (LINK.op[arr_pkg::OP_EN]) begin
                    if (!en) begin
                        next_en = 1'b1;
                        next_bank = LINK.op[arr_pkg::OP_BANK_HI:
                            arr_pkg::OP_BANK_LO];
                        next_pre_cnt = 2'h0;
                        next_clr_run = 1'b0;
                    end
                end else begin
                    // bank field left as is on a clearing write
                    next_en = 1'b0;
                    next_clr_run = 1'b0;
                end
            end
            arr_pkg::CMD_PRE, arr_pkg::CMD_PRECHARGE_ALL_BANKS: begin
                if (en && hit_pre && !clr_run) begin
                    next_pre_cnt = pre_cnt + 2'h1;
                    if (pre_cnt == arr_pkg::PASSES - 2'h1) begin
                        next_clr_run = 1'b1;
                        next_timer = arr_pkg::C_RP + arr_pkg::C_MRD
                            - 8'h1;
                    end
                end
            end
            arr_pkg::CMD_ACT: begin
                // activates never advance the refresh counter
                if (en && LINK.ba == bank) begin
                    next_agg = LINK.row;
                end
            end
            arr_pkg::CMD_REF: begin
                next_ref_cnt = ref_cnt + 16'h1;
            end
            default: begin
            end
        endcase
        if (clr_run) begin
            if (timer == 8'h0) begin
                next_en = 1'b0;
                next_clr_run = 1'b0;
                next_vic = 1'b1;
            end else begin
                next_timer = timer - 8'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            en <= 1'b0;
            bank <= 3'h0;
            pre_cnt <= 2'h0;
            timer <= 8'h0;
            clr_run <= 1'b0;
            agg <= 14'h0;
            vic <= 1'b0;
            ref_cnt <= 16'h0;
            unlim <= 1'b0;
        end else begin
            en <= next_en;
            bank <= next_bank;
            pre_cnt <= next_pre_cnt;
            timer <= next_timer;
            clr_run <= next_clr_run;
            agg <= next_agg;
            vic <= next_vic;
            ref_cnt <= next_ref_cnt;
            unlim <= (MAC_CODE == arr_pkg::MAC_UNLIMITED)
                && UNLIM_FLAG;
        end
    end

    assign LINK.rd_op = {en, bank, UNLIM_FLAG, MAC_CODE};
    assign MODE_ACTIVE_O = en;
    assign UNLIMITED_O = unlim;
    assign VICTIM_REFRESH_O = vic;
    assign VICTIM_BANK_O = bank;
    assign VICTIM_ROW_O = agg;
    assign REFRESH_COUNT_O = ref_cnt;
endmodule : arr_device

// ===== arr_ctrl.sv
/*
 controller end: avalon-mm slave registers and the adjacent-row
 refresh command sequencer. assumes the device at the link.
*/
// Decided for this implementation: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
module arr_ctrl (
    input wire logic CLK_I,
    input wire logic RST_B_I,
    input wire logic [3:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    output logic [31:0] AVS_READDATA_O,
    output logic AVS_WAITREQUEST_O,
    arr_link_if.ctrl LINK
);
    typedef enum logic [2:0] {
        S_IDLE = 3'h0,
        S_MRW = 3'h1,
        S_ACT = 3'h2,
        S_PRE = 3'h3,
        S_CLR = 3'h4,
        S_RCV = 3'h5
    } arr_state_e;

    arr_state_e state, next_state;
    logic [7:0] timer, next_timer;
    logic [1:0] pass, next_pass;
    arr_pkg::arr_cmd_e cmd, next_cmd;
    logic [2:0] ba, next_ba;
    logic [13:0] row, next_row;
    logic [7:0] op, next_op;
    logic [2:0] bank_sel, next_bank_sel;
    logic calib, next_calib;
    logic start_req, next_start_req;
    logic abort_req, next_abort_req;
    logic done, next_done;
    logic refused, next_refused;
    logic ack, next_ack;
    logic wait_req, next_wait_req;
    logic [31:0] rdata, next_rdata;
    logic wr_ctrl;
    logic [7:0] en_op;

    // ------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------
    always_comb begin
        next_ack = (AVS_READ_I || AVS_WRITE_I) && !ack;
        next_wait_req = !next_ack;
        // writes land on the edge that shows waitrequest low
        wr_ctrl = AVS_WRITE_I && ack && AVS_ADDRESS_I == arr_pkg::A_CTRL;
        next_bank_sel = bank_sel;
        next_calib = calib;
        next_row = row;
        next_rdata = rdata;
        if (wr_ctrl) begin
            next_bank_sel = AVS_WRITEDATA_I[arr_pkg::CT_BANK_LO +: 3];
            next_calib = AVS_WRITEDATA_I[arr_pkg::CT_CALIB];
        end
        if (AVS_WRITE_I && ack && AVS_ADDRESS_I == arr_pkg::A_ROW) begin
            next_row = AVS_WRITEDATA_I[13:0];
        end
        if (AVS_READ_I && !ack) begin
            unique case (AVS_ADDRESS_I)
                arr_pkg::A_CTRL: next_rdata = {23'h0, calib, 1'b0,
                    bank_sel, 2'h0, abort_req, start_req};
                arr_pkg::A_ROW: next_rdata = {18'h0, row};
                arr_pkg::A_STAT: next_rdata = {16'h0, LINK.rd_op,
                    1'b0, state, 1'b0, refused, done,
                    state != S_IDLE};
                default: next_rdata = 32'h0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // sequencer; one command at most per cycle, nothing else issued
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_timer = timer;
        next_pass = pass;
        next_cmd = arr_pkg::CMD_NOP;
        next_ba = ba;
        next_op = op;
        next_start_req = start_req;
        next_abort_req = abort_req;
        next_done = done;
        next_refused = refused;
        // other bits copied from the device's current value
        en_op = {1'b1, bank_sel, LINK.rd_op[3:0]};
        if (wr_ctrl) begin
            next_done = 1'b0;
            next_refused = 1'b0;
        end
        if (timer != 8'h0) begin
            next_timer = timer - 8'h1;
        end
        unique case (state)
            S_IDLE: begin
                if (abort_req) begin
                    next_abort_req = 1'b0;
                    next_cmd = arr_pkg::CMD_MRW;
                    next_op = {1'b0, op[6:0]};
                    next_timer = arr_pkg::C_MRD - 8'h1;
                    next_state = S_CLR;
                end else if (start_req) begin
                    next_start_req = 1'b0;
                    if (calib) begin
                        next_refused = 1'b1;
                    end else begin
                        // entered at the activate limit, from idle
                        // software keeps the per-victim activate budget
                        next_cmd = arr_pkg::CMD_MRW;
                        next_op = en_op;
                        next_ba = bank_sel;
                        next_pass = 2'h0;
                        next_timer = arr_pkg::C_MRD - 8'h1;
                        next_state = S_MRW;
                    end
                end
            end
            S_MRW, S_ACT, S_PRE: begin
                if (timer == 8'h0 && abort_req) begin
                    next_abort_req = 1'b0;
                    next_cmd = arr_pkg::CMD_MRW;
                    next_op = {1'b0, op[6:0]};
                    next_timer = arr_pkg::C_MRD - 8'h1;
                    next_state = S_CLR;
                end else if (timer == 8'h0 && state == S_ACT) begin
                    next_cmd = arr_pkg::CMD_PRE;
                    next_pass = pass + 2'h1;
                    if (pass == arr_pkg::PASSES - 2'h1) begin
                        next_timer = arr_pkg::C_RP + arr_pkg::C_MRD
                            - 8'h1;
                    end else begin
                        next_timer = arr_pkg::C_RP - 8'h1;
                    end
                    next_state = S_PRE;
                end else if (timer == 8'h0) begin
                    if (state == S_PRE && pass == arr_pkg::PASSES) begin
                        next_done = 1'b1;
                        next_state = S_IDLE;
                    end else begin
                        // spacing also keeps the activate window
                        next_cmd = arr_pkg::CMD_ACT;
                        if (pass == 2'h0) begin
                            next_timer = arr_pkg::C_RAS15 - 8'h1;
                        end else begin
                            next_timer = arr_pkg::C_RAS - 8'h1;
                        end
                        next_state = S_ACT;
                    end
                end
            end
            S_CLR, S_RCV: begin
                if (timer == 8'h0) begin
                    if (state == S_RCV && pass == arr_pkg::PASSES) begin
                        next_cmd = arr_pkg::CMD_MRW;
                        next_op = en_op;
                        next_pass = 2'h0;
                        next_timer = arr_pkg::C_MRD - 8'h1;
                        next_state = S_MRW;
                    end else begin
                        next_cmd = arr_pkg::CMD_PRE;
                        next_pass = (state == S_CLR) ? 2'h1 : pass + 2'h1;
                        next_timer = arr_pkg::C_RP - 8'h1;
                        next_state = S_RCV;
                    end
                end
            end
            default: begin
                next_state = S_IDLE;
            end
        endcase
        // a finish in the same cycle as a clearing write still shows
        if (state == S_PRE && timer == 8'h0 && pass == arr_pkg::PASSES
            && !abort_req) begin
            next_done = 1'b1;
        end
        // a new request wins over the one taken in the same cycle
        if (wr_ctrl && AVS_WRITEDATA_I[arr_pkg::CT_START]) begin
            next_start_req = 1'b1;
        end
        if (wr_ctrl && AVS_WRITEDATA_I[arr_pkg::CT_ABORT]) begin
            next_abort_req = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            state <= S_IDLE;
            timer <= 8'h0;
            pass <= 2'h0;
            cmd <= arr_pkg::CMD_NOP;
            ba <= 3'h0;
            row <= 14'h0;
            op <= 8'h0;
            bank_sel <= 3'h0;
            calib <= 1'b0;
            start_req <= 1'b0;
            abort_req <= 1'b0;
            done <= 1'b0;
            refused <= 1'b0;
            ack <= 1'b0;
            wait_req <= 1'b1;
            rdata <= 32'h0;
        end else begin
            state <= next_state;
            timer <= next_timer;
            pass <= next_pass;
            cmd <= next_cmd;
            ba <= next_ba;
            row <= next_row;
            op <= next_op;
            bank_sel <= next_bank_sel;
            calib <= next_calib;
            start_req <= next_start_req;
            abort_req <= next_abort_req;
            done <= next_done;
            refused <= next_refused;
            ack <= next_ack;
            wait_req <= next_wait_req;
            rdata <= next_rdata;
        end
    end

    assign AVS_WAITREQUEST_O = wait_req;
    assign AVS_READDATA_O = rdata;
    assign LINK.cmd = cmd;
    assign LINK.ba = ba;
    assign LINK.row = row;
    assign LINK.op = op;
endmodule : arr_ctrl

// ===== arr_link_assertions.sv
/*
 concurrent checks on the adjacent-row refresh command link.
 assumes one command clock and the link signals wired in by name.
*/
`timescale 1ns/1ps
module arr_link_assertions (
    input wire logic CLK_I,
    input wire logic RST_B_I,
    input wire arr_pkg::arr_cmd_e cmd,
    input wire logic [2:0] ba,
    input wire logic [13:0] row,
    input wire logic [7:0] op,
    input wire logic [7:0] rd_op
);
    // ------------------------------------------------------------
    // helper state: distance to and kind of the previous command, activates since the enable write and enabled bank
    // ------------------------------------------------------------
    logic [7:0] since;
    logic [7:0] next_since;
    arr_pkg::arr_cmd_e prev;
    arr_pkg::arr_cmd_e next_prev;
    logic [1:0] acts;
    logic [1:0] next_acts;
    logic [2:0] sel;
    logic [2:0] next_sel;
    logic en_wr;
    assign en_wr = (cmd == arr_pkg::CMD_MRW) && op[7];
    always_comb begin
        next_since = (since == 8'hff) ? since : since + 8'h01;
        next_prev = prev;
        next_acts = acts;
        next_sel = sel;
        if (cmd != arr_pkg::CMD_NOP) begin
            next_since = 8'h01;
            next_prev = cmd;
        end
        if (cmd == arr_pkg::CMD_ACT && acts != 2'h3) begin
            next_acts = acts + 2'h1;
        end
        if (en_wr) begin
            next_acts = 2'h0;
            next_sel = op[6:4];
        end
    end
    // saturating, so a long idle gap never wraps into a legal spacing
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            since <= 8'hff;
            prev <= arr_pkg::CMD_NOP;
            acts <= 2'h0;
            sel <= 3'h0;
        end else begin
            since <= next_since;
            prev <= next_prev;
            acts <= next_acts;
            sel <= next_sel;
        end
    end
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!RST_B_I);
    sequence s_third_pre;
        (cmd inside {arr_pkg::CMD_PRE, arr_pkg::CMD_PRECHARGE_ALL_BANKS}) && acts == 2'h3
            && rd_op[7];
    endsequence
    sequence s_en_held;
        rd_op[7] [*8];
    endsequence
    property p_self_clear;
        s_third_pre |=> s_en_held ##[1:3] !rd_op[7];
    endproperty
    a_self_clear: assert property (p_self_clear)
        else $error("mode enable did not self clear on time");
    property p_mrd;
        (cmd inside {arr_pkg::CMD_ACT, arr_pkg::CMD_PRE})
            && prev == arr_pkg::CMD_MRW |-> since == arr_pkg::C_MRD;
    endproperty
    a_mrd: assert property (p_mrd)
        else $error("command after mode write off its delay");
    property p_pre1;
        cmd == arr_pkg::CMD_PRE && prev == arr_pkg::CMD_ACT && acts == 2'h1
            |-> since == arr_pkg::C_RAS15;
    endproperty
    a_pre1: assert property (p_pre1)
        else $error("first precharge spacing wrong");
    property p_pre23;
        cmd == arr_pkg::CMD_PRE && prev == arr_pkg::CMD_ACT && acts >= 2'h2
            |-> since == arr_pkg::C_RAS;
    endproperty
    a_pre23: assert property (p_pre23)
        else $error("later precharge spacing wrong");
    property p_rp;
        (cmd inside {arr_pkg::CMD_ACT, arr_pkg::CMD_PRE})
            && prev == arr_pkg::CMD_PRE |-> since == arr_pkg::C_RP;
    endproperty
    a_rp: assert property (p_rp)
        else $error("command after precharge off its delay");
    property p_bank;
        (cmd inside {arr_pkg::CMD_ACT, arr_pkg::CMD_PRE}) |-> ba == sel;
    endproperty
    a_bank: assert property (p_bank)
        else $error("command aimed at another bank");
    property p_enable;
        en_wr |=> rd_op[7] && rd_op[6:4] == $past(op[6:4]);
    endproperty
    a_enable: assert property (p_enable)
        else $error("enable write not taken");
    property p_clear;
        cmd == arr_pkg::CMD_MRW && !op[7] |=> !rd_op[7];
    endproperty
    a_clear: assert property (p_clear)
        else $error("clearing write left mode on");
    property p_idle_entry;
        en_wr |-> !rd_op[7];
    endproperty
    a_idle_entry: assert property (p_idle_entry)
        else $error("enable write while mode active");
    property p_keep_bits;
        cmd == arr_pkg::CMD_MRW |-> op[3:0] == rd_op[3:0];
    endproperty
    a_keep_bits: assert property (p_keep_bits)
        else $error("mode write changed other register bits");
    property p_no_refresh;
        rd_op[7] |-> !(cmd inside {arr_pkg::CMD_REF, arr_pkg::CMD_SRE});
    endproperty
    a_no_refresh: assert property (p_no_refresh)
        else $error("refresh issued while mode active");
endmodule : arr_link_assertions

// ===== tb_top.sv
/*
 self-checking bench: controller and device joined by the link.
 assumes default device parameters and a 4 ns clock.
*/
`timescale 1ns/1ps
module tb_top;
    // unlimited flag set, count code zero: must match device parameters
    localparam logic [3:0] LOW_BITS = 4'h8;
    typedef struct {int t; logic [2:0] c; logic [2:0] ba;
        logic [13:0] row; logic [7:0] op;} arr_rec_s;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [3:0] addr = 4'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic wreq, mode, unl, vic;
    logic [2:0] vbank;
    logic [13:0] vrow;
    logic [15:0] rcnt;
    int bad_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    int vic_n = 0;
    logic [31:0] seed = 32'h8d35bd25;
    arr_rec_s lg[$];
    int dly[7];
    arr_pkg::arr_cmd_e kind[7];
    arr_link_if link();
    arr_ctrl arr_ctrl_i (.CLK_I(clk), .RST_B_I(rst_b), .AVS_ADDRESS_I(addr),
        .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata),
        .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wreq), .LINK(link));
    arr_device #(.MAC_CODE(3'h0), .UNLIM_FLAG(1'b1)) arr_device_i (
        .CLK_I(clk), .RST_B_I(rst_b), .LINK(link), .MODE_ACTIVE_O(mode),
        .UNLIMITED_O(unl), .VICTIM_REFRESH_O(vic), .VICTIM_BANK_O(vbank),
        .VICTIM_ROW_O(vrow), .REFRESH_COUNT_O(rcnt));
    arr_link_assertions arr_link_assertions_i (.CLK_I(clk), .RST_B_I(rst_b),
        .cmd(link.cmd), .ba(link.ba), .row(link.row), .op(link.op),
        .rd_op(link.rd_op));
    always #2 clk = ~clk;
    // ------------------------------------------------------------
    // link monitor and helpers
    // ------------------------------------------------------------
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (link.cmd !== arr_pkg::CMD_NOP) begin
            lg.push_back('{cyc, link.cmd, link.ba, link.row, link.op});
        end
        if (vic === 1'b1) begin
            vic_n <= vic_n + 1;
        end
    end
    function automatic logic [31:0] xorshift();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xorshift
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic test_done();
        $display("checks %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : test_done
    task automatic bus(input logic w, input logic [3:0] a,
        input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= d;
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 50);
        chk({31'h0, wreq}, 32'h0);
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : bus
    // ------------------------------------------------------------
    // one full sequence, optionally aborted after its first activate
    // ------------------------------------------------------------
    task automatic run(input logic [2:0] b, input logic [13:0] r,
        input bit stop);
        logic [31:0] q;
        int k, t, v0, n;
        v0 = vic_n;
        k = 0;
        lg.delete();
        bus(1'b1, arr_pkg::A_ROW, {18'h0, r}, q);
        bus(1'b1, arr_pkg::A_CTRL, (32'(b) << arr_pkg::CT_BANK_LO) | 32'h1, q);
        if (stop) begin
            for (n = 0; n < 100 && lg.size() < 2; n++) begin
                @(posedge clk);
            end
            bus(1'b1, arr_pkg::A_CTRL, (32'(b) << arr_pkg::CT_BANK_LO) | 32'h2,
                q);
        end
        n = 0;
        do begin
            bus(1'b0, arr_pkg::A_STAT, 32'h0, q);
            n++;
        end while (q[arr_pkg::ST_DONE] !== 1'b1 && n < 100);
        chk(q[arr_pkg::ST_DONE], 1'b1);
        chk(q[arr_pkg::ST_BUSY], 1'b0);
        repeat (2) @(posedge clk);
        if (stop) begin
            while (k < lg.size() && !(lg[k].c == arr_pkg::CMD_MRW
                && lg[k].op[7] == 1'b0))
                k++;
            for (n = 1; n < 4; n++) begin
                chk(lg[k + n].c, arr_pkg::CMD_PRE);
                chk(lg[k + n].ba, b);
                chk(lg[k + n].t - lg[k + n - 1].t,
                    (n == 1) ? arr_pkg::C_MRD : arr_pkg::C_RP);
            end
            k = k + 4;
        end
        t = (k > 0) ? lg[k - 1].t + arr_pkg::C_RP : lg[0].t;
        for (n = 0; n < 7; n++) begin
            t = t + dly[n];
            chk(lg[k + n].c, kind[n]);
            chk(lg[k + n].t, t);
            if (n == 0) chk(lg[k].op, {1'b1, b, LOW_BITS});
            else chk(lg[k + n].ba, b);
            if (kind[n] == arr_pkg::CMD_ACT) chk(lg[k + n].row, r);
        end
        chk(lg.size(), k + 7);
        chk(vic_n - v0, 1);
        chk(mode, 1'b0);
        chk(vbank, b);
        chk(vrow, r);
        chk(rcnt, 16'h0);
    endtask : run
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        test_done();
    end
    initial begin
        logic [31:0] q;
        int i;
        dly = '{0, arr_pkg::C_MRD, arr_pkg::C_RAS15, arr_pkg::C_RP,
            arr_pkg::C_RAS, arr_pkg::C_RP, arr_pkg::C_RAS};
        kind = '{arr_pkg::CMD_MRW, arr_pkg::CMD_ACT, arr_pkg::CMD_PRE,
            arr_pkg::CMD_ACT, arr_pkg::CMD_PRE, arr_pkg::CMD_ACT,
            arr_pkg::CMD_PRE};
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        bus(1'b0, arr_pkg::A_STAT, 32'h0, q);
        chk(q[15:8], {4'h0, LOW_BITS});
        chk(unl, 1'b1);
        bus(1'b0, 4'hc, 32'h0, q);
        chk(q, 32'h0);
        lg.delete();
        bus(1'b1, arr_pkg::A_CTRL, (32'h1 << arr_pkg::CT_CALIB) | 32'h1, q);
        bus(1'b0, arr_pkg::A_STAT, 32'h0, q);
        chk(q[arr_pkg::ST_REFUSED], 1'b1);
        chk(lg.size(), 0);
        bus(1'b1, arr_pkg::A_CTRL, 32'h0, q);
        run(3'h7, 14'h3fff, 1'b0);
        for (i = 0; i < 4; i++) begin
            q = xorshift();
            run(q[2:0], q[17:4], i == 2);
        end
        test_done();
    end
endmodule : tb_top
